// ===== logic/pms_pkg.sv
// constants, register map and types for the power mode sequencer
package pms_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LP_CTRL     = 8'h04;
    localparam logic [7:0] ADDR_CONV_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_UV_CTRL     = 8'h0c;
    localparam logic [7:0] ADDR_FAULT_TIME  = 8'h10;
    localparam logic [7:0] ADDR_FAULT_LOG   = 8'h14;
    localparam logic [7:0] ADDR_STATUS      = 8'h18;
    localparam logic [7:0] ADDR_EVENT       = 8'h1c;
    localparam logic [7:0] ADDR_EVENT_MASK  = 8'h20;
    // mode control fields
    localparam int MODE_LP_REQ_BIT  = 0;
    localparam int MODE_BOOT_ACT    = 1;
    localparam int MODE_ONKEY_EXIT  = 2;
    localparam int MODE_GPI_LP_SEL  = 3;
    // low-power override fields
    localparam int LP_AUTO_FREQ_BIT = 0;
    localparam int LP_CONV_DIS_BIT  = 1;
    localparam int LP_IO_OFF_BIT    = 2;
    // converter control fields
    localparam int CONV_EN_BIT      = 0;
    localparam int CONV_MODE_BIT    = 1;
    localparam int CONV_IO_EN_BIT   = 2;
    // under-voltage field layout: crit [4:0], hyst [7:5], warn [10:8]
    localparam int UV_CRIT_LSB      = 0;
    localparam int UV_HYST_LSB      = 5;
    localparam int UV_WARN_LSB      = 8;
    // crit: 4.6 V + n*50 mV, default 5.0 V -> 8; hyst: 50 mV + n*50 mV, default 200 mV -> 3
    localparam logic [4:0] UV_CRIT_RESET = 5'h08;
    localparam logic [4:0] UV_CRIT_MAX   = 5'h1f;
    localparam logic [2:0] UV_HYST_RESET = 3'h3;
    localparam logic [2:0] UV_WARN_RESET = 3'h0;
    // fault log bits
    localparam int FLT_UV   = 0;
    localparam int FLT_TEMP = 1;
    localparam int FLT_OC   = 2;
    localparam int FLT_RAMP = 3;
    localparam int FLT_POR  = 4;
    localparam logic [4:0] FLT_RESET = 5'h10;
    // reset values
    localparam logic [3:0] MODE_RESET  = 4'h0;
    localparam logic [2:0] LP_RESET    = 3'h0;
    localparam logic [2:0] CONV_RESET  = 3'h5;
    localparam logic [7:0] FTIME_RESET = 8'h0a;
    // timing: 50 MHz clock, 1 ms tick for fault wait, debounce in cycles
    localparam int CLK_HZ          = 50_000_000;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int RAMP_MS         = 20;
    localparam int DEBOUNCE_US     = 10;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_US;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        PMS_OFF     = 3'b000,
        PMS_PDOWN   = 3'b001,
        PMS_LOAD    = 3'b010,
        PMS_ACTIVE  = 3'b011,
        PMS_LOWPWR  = 3'b100,
        PMS_FAULT   = 3'b101
    } pms_state_t;
endpackage : pms_pkg

// ===== logic/pms_top.sv
// power mode sequencer: mode state machine, low-power overrides, supervision, APB registers
`timescale 1ns/100ps
module pms_top
    import pms_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        RESET_IN,
    // apb slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // supply and pins
    input  wire logic        CORE_RAIL_OK_IN,
    input  wire logic        ON_KEY_INPUT_N_IN,
    input  wire logic        GPI_LP_IN,
    input  wire logic        OTP_DONE_IN,
    // analogue supervision
    input  wire logic        UV_WARN_CMP_IN,
    input  wire logic        UV_CRIT_CMP_IN,
    input  wire logic        UV_RECOVER_CMP_IN,
    input  wire logic        CRITICAL_TEMP_BIT_CMP_IN,
    input  wire logic        CONV_ILIM_IN,
    input  wire logic        CONV_RAMP_OK_IN,
    // controls to analogue
    output logic             CORE_RESET_OUT,
    output logic             OTP_LOAD_OUT,
    output logic             CONV_ENABLE_OUT,
    output logic             CONV_AUTO_FREQ_OUT,
    output logic             OSC_REF_EN_OUT,
    output logic             IO_RAIL_EN_OUT,
    output logic             UV_CRIT_CMP_EN_OUT,
    output logic      [4:0]  UV_CRIT_LEVEL_OUT,
    output logic      [2:0]  UV_HYST_OUT,
    output logic      [2:0]  UV_WARN_LEVEL_OUT,
    output logic      [2:0]  MODE_OUT,
    output logic             INTERRUPT_OUTPUT_N_OUT
);
    pms_state_t state;
    pms_state_t next_state;
    logic [3:0]  mode_ctrl;
    logic [2:0]  lp_ctrl;
    logic [2:0]  conv_ctrl;
    logic [10:0] uv_ctrl;
    logic [7:0]  fault_time;
    logic [4:0]  fault_log;
    logic        ev_warn;
    logic        ev_mask;
    logic        on_key_q;
    logic [15:0] tick_cnt;
    logic [7:0]  ms_cnt;
    logic [9:0]  deb_cnt;
    logic        uv_crit;
    logic        uv_pending;

    // apb decode
    wire         wr_en  = PSEL_IN && PENABLE_IN && PWRITE_IN;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit
    wire         wr_mode  = wr_en && hit(PADDR_IN, ADDR_MODE_CTRL);
    wire         wr_lp    = wr_en && hit(PADDR_IN, ADDR_LP_CTRL);
    wire         wr_conv  = wr_en && hit(PADDR_IN, ADDR_CONV_CTRL);
    wire         wr_uv    = wr_en && hit(PADDR_IN, ADDR_UV_CTRL);
    wire         wr_ftime = wr_en && hit(PADDR_IN, ADDR_FAULT_TIME);
    wire         wr_flog  = wr_en && hit(PADDR_IN, ADDR_FAULT_LOG);
    wire         wr_event = wr_en && hit(PADDR_IN, ADDR_EVENT);
    wire         wr_emask = wr_en && hit(PADDR_IN, ADDR_EVENT_MASK);
    wire         addr_ok  = hit(PADDR_IN, ADDR_MODE_CTRL) || hit(PADDR_IN, ADDR_LP_CTRL)
                            || hit(PADDR_IN, ADDR_CONV_CTRL) || hit(PADDR_IN, ADDR_UV_CTRL)
                            || hit(PADDR_IN, ADDR_FAULT_TIME) || hit(PADDR_IN, ADDR_FAULT_LOG)
                            || hit(PADDR_IN, ADDR_STATUS) || hit(PADDR_IN, ADDR_EVENT)
                            || hit(PADDR_IN, ADDR_EVENT_MASK);

    // supervision
    wire         supervising = (state == PMS_ACTIVE) || (state == PMS_LOWPWR);
    wire         crit_cmp_en = supervising && UV_WARN_CMP_IN;
    wire         tick        = (tick_cnt == 16'(TICK_CYCLES - 1));
    wire         ramp_run    = (state == PMS_ACTIVE) && conv_ctrl[CONV_EN_BIT] && !CONV_RAMP_OK_IN;
    wire         ramp_fail   = ramp_run && (ms_cnt >= 8'(RAMP_MS)) && tick;
    wire         fault_now   = uv_crit || CRITICAL_TEMP_BIT_CMP_IN || CONV_ILIM_IN || ramp_fail;
    wire         fault_cond  = uv_pending || CRITICAL_TEMP_BIT_CMP_IN;
    wire         wait_done   = (ms_cnt >= fault_time);
    wire         key_press   = on_key_q && !ON_KEY_INPUT_N_IN;
    wire         gpi_mode    = mode_ctrl[MODE_GPI_LP_SEL];
    wire         lp_want     = gpi_mode ? GPI_LP_IN : mode_ctrl[MODE_LP_REQ_BIT];
    wire         key_exit    = mode_ctrl[MODE_ONKEY_EXIT] && lp_ctrl[LP_IO_OFF_BIT] && key_press;

    // debounce of the critical comparator so short spikes never shut down
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN || !crit_cmp_en || !UV_CRIT_CMP_IN) begin
            deb_cnt <= '0;
        end else if (deb_cnt != 10'(DEBOUNCE_CYCLES)) begin
            deb_cnt <= deb_cnt + 10'h001;
        end
    end
    assign uv_crit = (deb_cnt == 10'(DEBOUNCE_CYCLES));

    // latched until input recovers above level plus hysteresis
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            uv_pending <= 1'b0;
        end else if (uv_crit) begin
            uv_pending <= 1'b1;
        end else if (UV_RECOVER_CMP_IN) begin
            uv_pending <= 1'b0;
        end
    end

    // millisecond tick and counter for ramp and fault wait
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN || next_state != state || !(ramp_run || state == PMS_FAULT)) begin
            ms_cnt <= '0;
        end else if (tick && ms_cnt != 8'hff) begin
            ms_cnt <= ms_cnt + 8'h01;
        end
    end

    // mode state machine
    always_comb begin
        next_state = state;
        unique case (state)
            PMS_OFF:    next_state = CORE_RAIL_OK_IN ? (mode_ctrl[MODE_BOOT_ACT] ? PMS_LOAD : PMS_PDOWN) : PMS_OFF;
            PMS_PDOWN:  next_state = key_press ? PMS_LOAD : PMS_PDOWN;
            PMS_LOAD:   next_state = OTP_DONE_IN ? PMS_ACTIVE : PMS_LOAD;
            PMS_ACTIVE: begin
                if (fault_now) begin
                    next_state = PMS_FAULT;
                end else if (lp_want) begin
                    next_state = PMS_LOWPWR;
                end
            end
            PMS_LOWPWR: begin
                if (fault_now) begin
                    next_state = PMS_FAULT;
                end else if (!lp_want || key_exit) begin
                    next_state = PMS_ACTIVE;
                end
            end
            PMS_FAULT:  next_state = (wait_done && !fault_cond) ? PMS_LOAD : PMS_FAULT;
            default:    next_state = PMS_OFF;
        endcase
        if (!CORE_RAIL_OK_IN) begin
            next_state = PMS_OFF;
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            state <= PMS_OFF;
        end else begin
            state <= next_state;
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            on_key_q <= 1'b1;
        end else begin
            on_key_q <= ON_KEY_INPUT_N_IN;
        end
    end

    // configuration registers; stored values stay untouched by overrides
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            mode_ctrl  <= MODE_RESET;
            lp_ctrl    <= LP_RESET;
            conv_ctrl  <= CONV_RESET;
            uv_ctrl    <= {UV_WARN_RESET, UV_HYST_RESET, UV_CRIT_RESET};
            fault_time <= FTIME_RESET;
            ev_mask    <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_ctrl <= PWDATA_IN[3:0];
            end else if (key_exit) begin
                mode_ctrl[MODE_LP_REQ_BIT] <= 1'b0;
            end
            if (wr_lp) begin
                lp_ctrl <= PWDATA_IN[2:0];
            end
            // all conv_ctrl writes are refused in fault recovery while over temperature
            if (wr_conv && !(state == PMS_FAULT && CRITICAL_TEMP_BIT_CMP_IN)) begin
                conv_ctrl <= PWDATA_IN[2:0];
            end
            if (wr_uv) begin
                uv_ctrl <= {PWDATA_IN[UV_WARN_LSB +: 3], PWDATA_IN[UV_HYST_LSB +: 3],
                            PWDATA_IN[UV_CRIT_LSB +: 5]};
            end
            if (wr_ftime) begin
                fault_time <= PWDATA_IN[7:0];
            end
            if (wr_emask) begin
                ev_mask <= PWDATA_IN[0];
            end
        end
    end

    // fault record: hardware set wins over write-one clear; only reset clears otherwise
    // temperature stays watched in recovery so a rise there is still logged
    wire       temp_watch = supervising || (state == PMS_FAULT);
    wire [4:0] flt_set = {1'b0, ramp_fail, CONV_ILIM_IN && supervising,
                          CRITICAL_TEMP_BIT_CMP_IN && temp_watch, uv_crit};
    wire [4:0] flt_clr = wr_flog ? PWDATA_IN[4:0] : 5'h00;
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            fault_log <= FLT_RESET;
        end else begin
            fault_log <= (fault_log & ~flt_clr) | flt_set;
        end
    end

    // warning event: rising edge of warning comparator
    logic warn_q;
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            warn_q  <= 1'b0;
            ev_warn <= 1'b0;
        end else begin
            warn_q  <= UV_WARN_CMP_IN && supervising;
            if ((UV_WARN_CMP_IN && supervising) && !warn_q) begin
                ev_warn <= 1'b1;
            end else if (wr_event && PWDATA_IN[0]) begin
                ev_warn <= 1'b0;
            end
        end
    end

    // outputs to the analogue: overrides applied only in low power
    wire in_lp   = (state == PMS_LOWPWR);
    wire conv_on = ((state == PMS_ACTIVE) && conv_ctrl[CONV_EN_BIT])
                   || (in_lp && conv_ctrl[CONV_EN_BIT] && !lp_ctrl[LP_CONV_DIS_BIT]);
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            CONV_ENABLE_OUT    <= 1'b0;
            CONV_AUTO_FREQ_OUT <= 1'b0;
            IO_RAIL_EN_OUT     <= 1'b0;
            OSC_REF_EN_OUT     <= 1'b0;
        end else begin
            CONV_ENABLE_OUT    <= conv_on && !fault_now && next_state != PMS_FAULT;
            CONV_AUTO_FREQ_OUT <= conv_ctrl[CONV_MODE_BIT] || (in_lp && lp_ctrl[LP_AUTO_FREQ_BIT]);
            IO_RAIL_EN_OUT     <= (state == PMS_ACTIVE || in_lp) && conv_ctrl[CONV_IO_EN_BIT]
                                  && !(in_lp && lp_ctrl[LP_IO_OFF_BIT]);
            OSC_REF_EN_OUT     <= (state != PMS_PDOWN) && (state != PMS_OFF);
        end
    end
    assign CORE_RESET_OUT         = (state == PMS_OFF);
    assign OTP_LOAD_OUT           = (state == PMS_LOAD);
    assign UV_CRIT_CMP_EN_OUT     = crit_cmp_en;
    assign UV_CRIT_LEVEL_OUT      = uv_ctrl[UV_CRIT_LSB +: 5];
    assign UV_HYST_OUT            = uv_ctrl[UV_HYST_LSB +: 3];
    assign UV_WARN_LEVEL_OUT      = uv_ctrl[UV_WARN_LSB +: 3];
    assign MODE_OUT               = state;
    assign INTERRUPT_OUTPUT_N_OUT = !(ev_warn && !ev_mask);

    // apb read; zero wait states, unmapped address answers slverr
    wire [31:0] rd_mux =
        hit(PADDR_IN, ADDR_MODE_CTRL)  ? {28'h0, mode_ctrl} :
        hit(PADDR_IN, ADDR_LP_CTRL)    ? {29'h0, lp_ctrl} :
        hit(PADDR_IN, ADDR_CONV_CTRL)  ? {29'h0, conv_ctrl} :
        hit(PADDR_IN, ADDR_UV_CTRL)    ? {21'h0, uv_ctrl} :
        hit(PADDR_IN, ADDR_FAULT_TIME) ? {24'h0, fault_time} :
        hit(PADDR_IN, ADDR_FAULT_LOG)  ? {27'h0, fault_log} :
        hit(PADDR_IN, ADDR_STATUS)     ? {26'h0, CRITICAL_TEMP_BIT_CMP_IN, UV_WARN_CMP_IN && supervising, 1'b0, state} :
        hit(PADDR_IN, ADDR_EVENT)      ? {31'h0, ev_warn} :
        hit(PADDR_IN, ADDR_EVENT_MASK) ? {31'h0, ev_mask} : DATA_ZERO;
    assign PRDATA_OUT  = rd_mux;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

    a_fault_hold_off: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        state == PMS_FAULT |=> !CONV_ENABLE_OUT) else $error("converter on in fault recovery");
    a_pdown_no_fault: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        state == PMS_PDOWN |=> state != PMS_FAULT) else $error("fault entered from power-down");
    a_lp_io_off: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        state == PMS_LOWPWR && lp_ctrl[LP_IO_OFF_BIT] |=> !IO_RAIL_EN_OUT) else $error("io rail on in low power");
    a_lp_autofreq: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        state == PMS_LOWPWR && lp_ctrl[LP_AUTO_FREQ_BIT] |=> CONV_AUTO_FREQ_OUT) else $error("no auto freq");
    a_flog_sticky: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        fault_log[FLT_OC] && !(wr_flog && PWDATA_IN[FLT_OC]) |=> fault_log[FLT_OC]) else $error("log lost");
    a_flog_clear: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        wr_flog && PWDATA_IN[FLT_TEMP] && !flt_set[FLT_TEMP] |=> !fault_log[FLT_TEMP]) else $error("no w1c");
    a_load_first: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        state != PMS_ACTIVE && next_state == PMS_ACTIVE |-> state == PMS_LOAD || state == PMS_LOWPWR)
        else $error("active without load");
    a_irq_warn: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        $rose(ev_warn) && !ev_mask |-> !INTERRUPT_OUTPUT_N_OUT) else $error("irq missing");
    a_off_reset: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !CORE_RAIL_OK_IN |=> CORE_RESET_OUT) else $error("core not held in reset");
    c_lowpower: cover property (@(posedge MCLK_IN) state == PMS_ACTIVE ##1 state == PMS_LOWPWR);
    c_fault:    cover property (@(posedge MCLK_IN) state == PMS_FAULT ##1 state == PMS_LOAD);
    c_wake:     cover property (@(posedge MCLK_IN) state == PMS_PDOWN ##1 state == PMS_LOAD);
endmodule : pms_top

// ===== testbench/pms_analog_model.sv
// behavioural model of the configuration store and converter start-up
`timescale 1ns/100ps
module pms_analog_model (
    // clock
    input  wire logic clk_in,
    // requests from the sequencer
    input  wire logic otp_load_in,
    input  wire logic conv_enable_in,
    // answers
    output logic      otp_done_out,
    output logic      ramp_ok_out
);
    logic [3:0] load_cnt;
    logic [3:0] ramp_cnt;
    // short fixed latencies keep the run brief; real load and ramp take far longer
    always_ff @(posedge clk_in) begin
        load_cnt <= otp_load_in ? load_cnt + {3'h0, load_cnt != 4'h4} : 4'h0;
        ramp_cnt <= conv_enable_in ? ramp_cnt + {3'h0, ramp_cnt != 4'h8} : 4'h0;
    end
    assign otp_done_out = (load_cnt == 4'h4);
    assign ramp_ok_out  = (ramp_cnt == 4'h8);
endmodule : pms_analog_model

// ===== testbench/power_mode_sequencer_bench.sv
// self-checking bench for the power mode sequencer
`timescale 1ns/100ps
module power_mode_sequencer_bench;
    import pms_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, key_n = 1, gpi = 0;
    logic warn = 0, crit = 0, temp = 0, ilim = 0, otp_done, ramp_ok, rail = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    logic err;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, otp_load, conv_en, auto_f, osc_en, io_en, crit_en, irq_n, core_rst;
    wire logic [2:0] mode;
    int bad_count = 0, comparisons = 0;
    always #10 clk = ~clk;
    pms_top uut (.MCLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .CORE_RAIL_OK_IN(rail), .ON_KEY_INPUT_N_IN(key_n), .GPI_LP_IN(gpi),
        .OTP_DONE_IN(otp_done), .UV_WARN_CMP_IN(warn), .UV_CRIT_CMP_IN(crit), .UV_RECOVER_CMP_IN(~crit),
        .CRITICAL_TEMP_BIT_CMP_IN(temp), .CONV_ILIM_IN(ilim), .CONV_RAMP_OK_IN(ramp_ok), .CORE_RESET_OUT(core_rst),
        .OTP_LOAD_OUT(otp_load), .CONV_ENABLE_OUT(conv_en), .CONV_AUTO_FREQ_OUT(auto_f),
        .OSC_REF_EN_OUT(osc_en), .IO_RAIL_EN_OUT(io_en), .UV_CRIT_CMP_EN_OUT(crit_en),
        .UV_CRIT_LEVEL_OUT(), .UV_HYST_OUT(), .UV_WARN_LEVEL_OUT(), .MODE_OUT(mode),
        .INTERRUPT_OUTPUT_N_OUT(irq_n));
    pms_analog_model partner (.clk_in(clk), .otp_load_in(otp_load), .conv_enable_in(conv_en),
        .otp_done_out(otp_done), .ramp_ok_out(ramp_ok));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    // request held until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk) n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask : rdchk
    task wait_mode(input logic [2:0] m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge clk) n++;
        end
        repeat (3) @(posedge clk);
        chk(mode, m, "mode");
    endtask : wait_mode
    task t_boot;
        wait_mode(PMS_PDOWN, 50);
        chk({conv_en, osc_en, io_en}, 3'h0, "pdown outputs");
        rdchk(ADDR_CONV_CTRL, 32'h5, "conv reset");
        rdchk(ADDR_UV_CTRL, 32'h068, "uv reset");
        rdchk(ADDR_FAULT_LOG, 32'h10, "log reset");
        apb(1'b0, 8'h40, 32'h0);
        chk({err, q}, {1'b1, 32'h0}, "unmapped");
        @(posedge clk) ilim <= 1'b1;
        @(posedge clk) ilim <= 1'b0;
        wait_mode(PMS_PDOWN, 0);
    endtask : t_boot
    task t_wake;
        @(posedge clk) key_n <= 1'b0;
        repeat (5) @(posedge clk);
        key_n <= 1'b1;
        wait_mode(PMS_ACTIVE, 200);
        chk({conv_en, auto_f, io_en, osc_en}, 4'hb, "active outputs");
    endtask : t_wake
    task t_lowpwr;
        apb(1'b1, ADDR_LP_CTRL, 32'h7);
        apb(1'b1, ADDR_MODE_CTRL, 32'h1);
        wait_mode(PMS_LOWPWR, 20);
        chk({conv_en, auto_f, io_en}, 3'h2, "overrides");
        apb(1'b1, ADDR_MODE_CTRL, 32'h0);
        wait_mode(PMS_ACTIVE, 200);
        chk({conv_en, auto_f, io_en}, 3'h5, "restored");
        // gpi path with every override off: nothing may change
        apb(1'b1, ADDR_LP_CTRL, 32'h0);
        apb(1'b1, ADDR_MODE_CTRL, 32'h8);
        gpi <= 1'b1;
        wait_mode(PMS_LOWPWR, 20);
        chk({conv_en, auto_f, io_en}, 3'h5, "no override");
        gpi <= 1'b0;
        wait_mode(PMS_ACTIVE, 200);
        apb(1'b1, ADDR_MODE_CTRL, 32'h0);
    endtask : t_lowpwr
    task t_warn;
        @(posedge clk) warn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({crit_en, irq_n}, 2'h2, "warn trip");
        rdchk(ADDR_STATUS, 32'h13, "status");
        rdchk(ADDR_EVENT, 32'h1, "event");
        // spike well below the debounce span must not shut down
        crit <= 1'b1;
        repeat (100) @(posedge clk);
        crit <= 1'b0;
        wait_mode(PMS_ACTIVE, 0);
        apb(1'b1, ADDR_EVENT_MASK, 32'h1);
        @(negedge clk);
        chk(irq_n, 1'b1, "masked");
        apb(1'b1, ADDR_EVENT_MASK, 32'h0);
        warn <= 1'b0;
        apb(1'b1, ADDR_EVENT, 32'h1);
        @(negedge clk);
        chk(irq_n, 1'b1, "event cleared");
    endtask : t_warn
    task t_fault;
        apb(1'b1, ADDR_FAULT_TIME, 32'h1);
        @(posedge clk) ilim <= 1'b1;
        @(posedge clk) ilim <= 1'b0;
        wait_mode(PMS_FAULT, 20);
        chk(conv_en, 1'b0, "fault conv");
        rdchk(ADDR_FAULT_LOG, 32'h14, "oc log");
        temp <= 1'b1;
        apb(1'b1, ADDR_CONV_CTRL, 32'h0);
        rdchk(ADDR_CONV_CTRL, 32'h5, "refused");
        repeat (52000) @(posedge clk);
        chk({mode, conv_en}, {PMS_FAULT, 1'b0}, "hot");
        temp <= 1'b0;
        wait_mode(PMS_ACTIVE, 500);
        rdchk(ADDR_FAULT_LOG, 32'h16, "log kept");
        apb(1'b1, ADDR_FAULT_LOG, 32'h6);
        rdchk(ADDR_FAULT_LOG, 32'h10, "w1c");
    endtask : t_fault
    task t_rail;
        @(posedge clk) rail <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({core_rst, mode}, {1'b1, PMS_OFF}, "rail low");
        @(posedge clk) rail <= 1'b1;
        wait_mode(PMS_PDOWN, 20);
    endtask : t_rail
    task test_done;
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_wake();
        t_lowpwr();
        t_warn();
        t_fault();
        t_rail();
        test_done();
    end
    initial begin
        #(90000 * 20);
        bad_count++;
        test_done();
    end
endmodule : power_mode_sequencer_bench
